// File: verilog/fast_counter_pkg.sv
// Shared constants, register map and state types of the high-speed counter block.
package fast_counter_pkg;

   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int NUM_CH = 4;  // Number of counter instances.
   localparam int SRC_W = 2;  // Width of the input select field.
   localparam logic signed [31:0] CNT_MAX = 32'sh7FFFFFFF;  // Highest count, +2147483647.
   localparam logic signed [31:0] CNT_MIN = 32'sh80000000;  // Lowest count, -2147483648.

   // ------------------------------------------------------------
   // Register map, byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0] CH_STRIDE = 8'h20;  // Spacing of the per-channel banks.
   localparam logic [4:0] OFF_CTRL = 5'h00;  // Coils and options.
   localparam logic [4:0] OFF_UPPER = 5'h04;  // Upper setpoint.
   localparam logic [4:0] OFF_LOWER = 5'h08;  // Lower setpoint.
   localparam logic [4:0] OFF_START = 5'h0C;  // Start value.
   localparam logic [4:0] OFF_ACTUAL = 5'h10;  // Actual value, read only.
   localparam logic [4:0] OFF_STATUS = 5'h14;  // Flags, read only.
   localparam logic [7:0] ADDR_RUN = 8'h80;  // Global run/stop control.

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CTRL_EN = 0;  // Enable coil.
   localparam int CTRL_CLR = 1;  // Clear coil.
   localparam int CTRL_DIR = 2;  // Direction coil, 1 counts up.
   localparam int CTRL_PRE = 3;  // Preset-load coil.
   localparam int CTRL_SRC = 4;  // Low bit of the input select field.
   localparam int CTRL_SHOW = 6;  // Parameter visibility.
   localparam int CTRL_W = 7;  // Width of the control register.
   localparam int ST_UP = 0;  // Upper reached flag.
   localparam int ST_LO = 1;  // Lower reached flag.
   localparam int ST_ZE = 2;  // Zero flag.
   localparam int ST_CY = 3;  // Range exceeded flag.
   localparam int ST_ACT = 4;  // Instance owns its input.
   localparam int ST_RET = 5;  // Instance is retentive.

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [CTRL_W-1:0] CTRL_RST = 7'h40;  // Parameters shown, coils off.
   localparam logic [31:0] SP_RST = 32'h00000000;  // Setpoints and start value.

   // ------------------------------------------------------------
   // State types
   // ------------------------------------------------------------
   typedef struct packed {
      logic run_prev;  // Run level one cycle ago.
      logic pulse_prev;  // Synchronised count input one cycle ago.
      logic preset_prev;  // Preset coil one cycle ago.
      logic [31:0] actual;  // Actual count value.
      logic up;  // Upper reached flag.
      logic lo;  // Lower reached flag.
      logic ze;  // Zero flag.
      logic cy;  // Range exceeded flag.
   } chan_state_t;

   typedef struct packed {
      logic [NUM_CH-1:0] sync1;  // First synchroniser stage.
      logic [NUM_CH-1:0] sync2;  // Second synchroniser stage.
      logic a_valid;  // Data phase pending.
      logic a_write;  // Pending transfer is a write.
      logic [7:0] a_addr;  // Pending byte address.
      logic [31:0] rdata;  // Registered read data.
      logic run;  // Controller in run state.
      logic [NUM_CH-1:0][CTRL_W-1:0] ctrl;  // Control registers.
      logic [NUM_CH-1:0][31:0] upper;  // Upper setpoints.
      logic [NUM_CH-1:0][31:0] lower;  // Lower setpoints.
      logic [NUM_CH-1:0][31:0] start;  // Start values.
   } top_state_t;

endpackage

// File: verilog/counter_channel.sv
// One counter instance: edge counting, preset, clear, saturation and comparison flags.
`timescale 1ns/1ns
module counter_channel #(
   parameter bit RETAIN = 1'b0  // Keep the actual value over stop and supply loss.
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic srst,
   // Synchronised count input and controls.
   input wire logic pulse_in,
   input wire logic run,
   input wire logic enable,
   input wire logic clear,
   input wire logic dir,
   input wire logic preset,
   input wire logic active,
   // Setpoints and start value.
   input wire logic [31:0] upper_sp,
   input wire logic [31:0] lower_sp,
   input wire logic [31:0] start_val,
   // Results.
   output logic [31:0] actual_value_out,
   output logic upper_reached_flag,
   output logic lower_reached_flag,
   output logic zero_flag,
   output logic range_exceeded_flag
);
   import fast_counter_pkg::*;

   chan_state_t q;  // Registered state.
   chan_state_t d;  // Next state.
   logic rise;  // Rising edge on the count input.
   logic go;  // Instance may take its preset and count edges.

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   // Clear beats preset and preset beats a count, so a coil never races a pulse.
   always_comb begin
      d = q;
      d.run_prev = run;
      d.pulse_prev = pulse_in;
      d.preset_prev = preset;
      rise = pulse_in & ~q.pulse_prev;
      go = run & enable & active;
      if (run & ~q.run_prev & ~RETAIN) begin
         // A non-retentive instance begins each run from zero.
         d.actual = SP_RST;
         d.cy = 1'b0;
      end else if (run & clear) begin
         // Only the clear coil in run zeroes a running value.
         d.actual = SP_RST;
         d.cy = 1'b0;
      end else if (go & preset & ~q.preset_prev) begin
         d.actual = start_val;
         d.cy = 1'b0;
      end else if (go & rise) begin
         if (dir) begin
            // Count up, holding the last valid value at the top.
            if ($signed(q.actual) == CNT_MAX) begin
               d.cy = 1'b1;
            end else begin
               d.actual = q.actual + 32'h00000001;
            end
         end else begin
            // Count down, holding the last valid value at the bottom.
            if ($signed(q.actual) == CNT_MIN) begin
               d.cy = 1'b1;
            end else begin
               d.actual = q.actual - 32'h00000001;
            end
         end
      end
      // Flags follow the new value in the same edge, signed compare.
      d.up = $signed(d.actual) >= $signed(upper_sp);
      d.lo = $signed(d.actual) <= $signed(lower_sp);
      d.ze = d.actual == SP_RST;
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   // A retentive value survives reset, which stands in for supply loss.
   always_ff @(posedge clk) begin
      if (srst) begin
         q <= '0;
         if (RETAIN) begin
            q.actual <= q.actual;
         end
      end else begin
         q <= d;
      end
   end

   assign actual_value_out = q.actual;
   assign upper_reached_flag = q.up;
   assign lower_reached_flag = q.lo;
   assign zero_flag = q.ze;
   assign range_exceeded_flag = q.cy;

endmodule // counter_channel

// File: verilog/fast_counter_block.sv
// Four high-speed up/down counters behind an AHB-Lite register slave.
//
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ns

module fast_counter_block #(
   parameter logic [3:0] RETAIN_MASK = 4'h0  // Retentive instances, one bit each.
) (
   // Clock and reset.
   input wire logic MCLK,
   input wire logic SRST,
   // Count input pins.
   input wire logic [fast_counter_pkg::NUM_CH-1:0] CNT_IN,
   // AHB-Lite slave.
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // Counter contacts, one bit per instance.
   output logic [fast_counter_pkg::NUM_CH-1:0] UPPER_REACHED_FLAG,
   output logic [fast_counter_pkg::NUM_CH-1:0] LOWER_REACHED_FLAG,
   output logic [fast_counter_pkg::NUM_CH-1:0] ZERO_FLAG,
   output logic [fast_counter_pkg::NUM_CH-1:0] RANGE_EXCEEDED_FLAG,
   output logic [fast_counter_pkg::NUM_CH-1:0] PARAM_SHOWN,
   output logic [fast_counter_pkg::NUM_CH-1:0] RUN_ACTIVE
);
   import fast_counter_pkg::*;

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   top_state_t q;  // Registered state.
   top_state_t d;  // Next state.
   logic [NUM_CH-1:0] active;  // Instance owns its input.
   logic [NUM_CH-1:0] pulse;  // Selected synchronised input per instance.
   logic [NUM_CH-1:0][31:0] actual;  // Actual values from the instances.
   logic [NUM_CH-1:0][5:0] status;  // Status words from the instances.
   logic take;  // Address phase accepted this edge.

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Input select field of a control word.
   function automatic logic [SRC_W-1:0] src_of(input logic [CTRL_W-1:0] c);
      src_of = c[CTRL_SRC+:SRC_W];
   endfunction

   // Reset value of a control word: instance n listens on input n.
   function automatic logic [CTRL_W-1:0] ctrl_rst(input int n);
      logic [CTRL_W-1:0] c;
      c = CTRL_RST;
      c[CTRL_SRC+:SRC_W] = SRC_W'(n);
      ctrl_rst = c;
   endfunction

   // ------------------------------------------------------------
   // Input ownership
   // ------------------------------------------------------------
   // An enabled later instance on the same input takes it from all earlier ones.
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         active[i] = 1'b1;
         for (int j = i + 1; j < NUM_CH; j++) begin
            if (q.ctrl[j][CTRL_EN] && src_of(q.ctrl[j]) == src_of(q.ctrl[i])) begin
               active[i] = 1'b0;
            end
         end
         pulse[i] = q.sync2[src_of(q.ctrl[i])];
      end
   end

   // ------------------------------------------------------------
   // Register slave and synchronisers
   // ------------------------------------------------------------
   // Writes land in the data phase; the read mux sees the merged state, so a
   // read right after a write to the same register returns the new value.
   always_comb begin
      logic [1:0] ch;
      logic [4:0] off;
      d = q;
      ch = 2'b00;
      off = 5'b00000;
      d.sync1 = CNT_IN;
      d.sync2 = q.sync1;
      take = HSEL & HTRANS[1] & HREADY;
      // Data phase of a pending write.
      if (q.a_valid & q.a_write) begin
         ch = q.a_addr[6:5];
         off = q.a_addr[4:0];
         if (q.a_addr == ADDR_RUN) begin
            d.run = HWDATA[0];
         end else if (q.a_addr[7]) begin
            // Unmapped: the write is dropped.
            d.run = q.run;
         end else if (off == OFF_CTRL) begin
            d.ctrl[ch] = HWDATA[CTRL_W-1:0];
         end else if (off == OFF_UPPER) begin
            d.upper[ch] = HWDATA;
         end else if (off == OFF_LOWER) begin
            d.lower[ch] = HWDATA;
         end else if (off == OFF_START) begin
            d.start[ch] = HWDATA;
         end
      end
      // Address phase: latch it and prepare read data.
      d.a_valid = take;
      d.a_write = HWRITE;
      d.a_addr = HADDR[7:0];
      d.rdata = 32'h00000000;
      if (take & ~HWRITE) begin
         ch = HADDR[6:5];
         off = HADDR[4:0];
         if (HADDR[7:0] == ADDR_RUN) begin
            d.rdata = {31'h00000000, d.run};
         end else if (HADDR[7]) begin
            // Unmapped reads return zero.
            d.rdata = 32'h00000000;
         end else if (off == OFF_CTRL) begin
            d.rdata = {25'h0000000, d.ctrl[ch]};
         end else if (off == OFF_UPPER) begin
            d.rdata = d.upper[ch];
         end else if (off == OFF_LOWER) begin
            d.rdata = d.lower[ch];
         end else if (off == OFF_START) begin
            d.rdata = d.start[ch];
         end else if (off == OFF_ACTUAL) begin
            d.rdata = actual[ch];
         end else if (off == OFF_STATUS) begin
            d.rdata = {26'h0000000, status[ch]};
         end
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         q <= '0;
         for (int n = 0; n < NUM_CH; n++) begin
            q.ctrl[n] <= ctrl_rst(n);
         end
      end else begin
         q <= d;
      end
   end

   // ------------------------------------------------------------
   // Counter instances
   // ------------------------------------------------------------
   // Each instance counts on its own edges, not on any program cycle.
   for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
      counter_channel #(
         .RETAIN(RETAIN_MASK[g])
      ) u_ch (
         .clk(MCLK),
         .srst(SRST),
         .pulse_in(pulse[g]),
         .run(q.run),
         .enable(q.ctrl[g][CTRL_EN]),
         .clear(q.ctrl[g][CTRL_CLR]),
         .dir(q.ctrl[g][CTRL_DIR]),
         .preset(q.ctrl[g][CTRL_PRE]),
         .active(active[g]),
         .upper_sp(q.upper[g]),
         .lower_sp(q.lower[g]),
         .start_val(q.start[g]),
         .actual_value_out(actual[g]),
         .upper_reached_flag(UPPER_REACHED_FLAG[g]),
         .lower_reached_flag(LOWER_REACHED_FLAG[g]),
         .zero_flag(ZERO_FLAG[g]),
         .range_exceeded_flag(RANGE_EXCEEDED_FLAG[g])
      );
      // Status word gathers the contacts and ownership.
      assign status[g] = {RETAIN_MASK[g], active[g], RANGE_EXCEEDED_FLAG[g],
                          ZERO_FLAG[g], LOWER_REACHED_FLAG[g], UPPER_REACHED_FLAG[g]};
      assign PARAM_SHOWN[g] = q.ctrl[g][CTRL_SHOW];
      assign RUN_ACTIVE[g] = active[g] & q.ctrl[g][CTRL_EN] & q.run;
   end

   // ------------------------------------------------------------
   // Bus outputs
   // ------------------------------------------------------------
   // Zero wait states; HSIZE is accepted but only whole words are meaningful.
   assign HRDATA = q.rdata;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;

endmodule // fast_counter_block

// File: test/fast_counter_block_asserts.sv
// Port-level checker for the high-speed counter block.
`timescale 1ns/1ns
module fast_counter_block_asserts (
   // Clock and reset.
   input wire logic MCLK,
   input wire logic SRST,
   // Count pins and bus.
   input wire logic [fast_counter_pkg::NUM_CH-1:0] CNT_IN,
   input wire logic HSEL,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic HREADYOUT,
   // Contacts and status levels.
   input wire logic [fast_counter_pkg::NUM_CH-1:0] UPPER_REACHED_FLAG,
   input wire logic [fast_counter_pkg::NUM_CH-1:0] LOWER_REACHED_FLAG,
   input wire logic [fast_counter_pkg::NUM_CH-1:0] ZERO_FLAG,
   input wire logic [fast_counter_pkg::NUM_CH-1:0] RANGE_EXCEEDED_FLAG,
   input wire logic [fast_counter_pkg::NUM_CH-1:0] PARAM_SHOWN,
   input wire logic [fast_counter_pkg::NUM_CH-1:0] RUN_ACTIVE
);
   import fast_counter_pkg::*;
   logic take;  // Transfer taken at this edge.
   logic rd_q;  // A read data phase is running.
   logic [NUM_CH-1:0] pin_q;  // Count pins one cycle ago.
   logic [3:0] wr_age_q;  // Cycles since the last write or reset, saturating.
   logic [3:0] ev_age_q;  // Cycles since the last write, pin change or reset.
   assign take = HSEL & HTRANS[1] & HREADY;
   // Age counters give every cause a bounded window outside which its effect must not show.
   always_ff @(posedge MCLK) begin
      rd_q <= take & ~HWRITE & ~SRST;
      pin_q <= CNT_IN;
      if (SRST | (take & HWRITE)) begin
         wr_age_q <= 4'h0;
      end else if (wr_age_q != 4'hF) begin
         wr_age_q <= wr_age_q + 4'h1;
      end
      if (SRST | (take & HWRITE) | (CNT_IN != pin_q)) begin
         ev_age_q <= 4'h0;
      end else if (ev_age_q != 4'hF) begin
         ev_age_q <= ev_age_q + 4'h1;
      end
   end
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (SRST);
   property p_ready_high; HREADYOUT == 1'b1; endproperty
   a_ready_high: assert property (p_ready_high) else $error("slave stalled the bus");
   property p_rdata_idle; !rd_q |-> HRDATA == 32'h0; endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside a read");
   property p_flags_cause;
      $changed({UPPER_REACHED_FLAG, LOWER_REACHED_FLAG, ZERO_FLAG, RANGE_EXCEEDED_FLAG}) |-> ev_age_q < 4'h6;
   endproperty
   a_flags_cause: assert property (p_flags_cause) else $error("flag moved without a cause");
   property p_run_active; $changed(RUN_ACTIVE) |-> wr_age_q == 4'h1; endproperty
   a_run_active: assert property (p_run_active) else $error("activity moved without a write");
   property p_count_gate;
      ($changed({UPPER_REACHED_FLAG[0], LOWER_REACHED_FLAG[0], ZERO_FLAG[0], RANGE_EXCEEDED_FLAG[0]})
         && wr_age_q > 4'h4) |-> RUN_ACTIVE[0];
   endproperty
   a_count_gate: assert property (p_count_gate) else $error("inactive counter moved");
   property p_show_reset; $fell(SRST) |-> PARAM_SHOWN == 4'hF; endproperty
   a_show_reset: assert property (p_show_reset) else $error("parameters hidden after reset");
   property p_show_cause; $changed(PARAM_SHOWN) |-> wr_age_q inside {[4'h1:4'h2]}; endproperty
   a_show_cause: assert property (p_show_cause) else $error("visibility moved without a write");
   property p_range_fall;
      (|($past(RANGE_EXCEEDED_FLAG) & ~RANGE_EXCEEDED_FLAG)) |-> wr_age_q < 4'h4;
   endproperty
   a_range_fall: assert property (p_range_fall) else $error("range flag dropped by itself");
endmodule  // fast_counter_block_asserts

bind fast_counter_block fast_counter_block_asserts fast_counter_block_asserts_inst (.MCLK(MCLK), .SRST(SRST),
   .CNT_IN(CNT_IN), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
   .HREADYOUT(HREADYOUT), .UPPER_REACHED_FLAG(UPPER_REACHED_FLAG), .LOWER_REACHED_FLAG(LOWER_REACHED_FLAG),
   .ZERO_FLAG(ZERO_FLAG), .RANGE_EXCEEDED_FLAG(RANGE_EXCEEDED_FLAG), .PARAM_SHOWN(PARAM_SHOWN),
   .RUN_ACTIVE(RUN_ACTIVE));

// File: test/pulse_source.sv
// Square-wave pulse source that drives the four count pins.
`timescale 1ns/1ns
module pulse_source (
   // Clock and command.
   input wire logic clk,
   input wire logic go,
   input wire logic [1:0] sel,
   input wire logic [7:0] num,
   input wire logic [7:0] half,
   // Pins and state.
   output logic [3:0] pins,
   output logic busy
);
   logic [7:0] left;  // Pulses still to send.
   logic [7:0] tick;  // Cycles spent in the current half period.
   logic lvl;  // Level of the selected pin.
   logic [1:0] cur;  // Pin in use.
   initial begin
      busy = 1'b0;
   end
   // Equal high and low halves; the rate is compressed so that the run stays short.
   always @(posedge clk) begin
      if (!busy && go) begin
         busy <= 1'b1;
         left <= num;
         cur <= sel;
         tick <= 8'h00;
         lvl <= 1'b0;
      end else if (busy && tick == half - 8'h01) begin
         tick <= 8'h00;
         lvl <= ~lvl;
         if (lvl) begin
            left <= left - 8'h01;
            busy <= (left != 8'h01);
         end
      end else if (busy) begin
         tick <= tick + 8'h01;
      end
   end
   // Idle pins rest low, as a pulled-down input would.
   assign pins = busy ? ({3'b000, lvl} << cur) : 4'h0;
endmodule  // pulse_source

// File: test/fast_counter_block_tb.sv
// Self-checking bench for the high-speed counter block.
`timescale 1ns/1ns
module fast_counter_block_tb;
   import fast_counter_pkg::*;
   typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} row_t;
   logic mclk, srst, hsel, hwrite, hreadyout, hresp, go, busy;
   logic [1:0] htrans, psel;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [7:0] pnum, phalf;
   logic [NUM_CH-1:0] cnt_in, upper, lower, zero, range, shown, active;
   int err_total, tests_run;
   // Register rows: address, write flag, data, expected read-back.
   row_t rows[9] = '{'{8'h00, 1'b0, 32'h0, 32'h40}, '{8'h20, 1'b0, 32'h0, 32'h50},
      '{8'h40, 1'b0, 32'h0, 32'h60}, '{8'h60, 1'b0, 32'h0, 32'h70}, '{8'h10, 1'b0, 32'h0, 32'h0},
      '{8'h04, 1'b1, 32'h80000000, 32'h80000000}, '{8'h08, 1'b1, 32'h7FFFFFFF, 32'h7FFFFFFF},
      '{8'h1C, 1'b1, 32'h1234, 32'h0}, '{8'h80, 1'b1, 32'h1, 32'h1}};
   fast_counter_block #(.RETAIN_MASK(4'h2)) fast_counter_block_inst (.MCLK(mclk), .SRST(srst), .CNT_IN(cnt_in),
      .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata),
      .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .UPPER_REACHED_FLAG(upper),
      .LOWER_REACHED_FLAG(lower), .ZERO_FLAG(zero), .RANGE_EXCEEDED_FLAG(range), .PARAM_SHOWN(shown),
      .RUN_ACTIVE(active));
   pulse_source pulse_source_inst (.clk(mclk), .go(go), .sel(psel), .num(pnum), .half(phalf), .pins(cnt_in),
      .busy(busy));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic hang();
      err_total++;
      $display("[FAIL] wait expected done seen timeout");
      end_of_test();
   endtask
   // One single AHB transfer; the address phase is held until ready is seen.
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      int k;
      @(posedge mclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      k = 0;
      do begin @(posedge mclk); k++; end while (hreadyout !== 1'b1 && k < 50);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do begin @(posedge mclk); k++; end while (hreadyout !== 1'b1 && k < 100);
      rd = hrdata;
      if (k >= 100) hang();
   endtask
   // Writes wait for the flags to follow before anyone looks at them.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
      repeat (3) @(posedge mclk);
   endtask
   task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
      bus(a, 1'b0, 32'h0);
      chk(n, e, rd);
      chk("okay response", 32'h0, {31'h0, hresp});
   endtask
   task automatic pulses(input logic [1:0] p, input logic [7:0] n, input logic [7:0] h);
      int k;
      @(posedge mclk);
      go <= 1'b1;
      psel <= p;
      pnum <= n;
      phalf <= h;
      @(posedge mclk);
      go <= 1'b0;
      @(posedge mclk);
      k = 0;
      while (busy !== 1'b0 && k < 5000) begin @(posedge mclk); k++; end
      if (k >= 5000) hang();
      repeat (6) @(posedge mclk);
   endtask
   // Channel 0 contacts packed as upper, lower, zero.
   function automatic logic [31:0] f0();
      return {29'h0, upper[0], lower[0], zero[0]};
   endfunction
   initial begin
      {srst, hsel, haddr, htrans, hwrite, hwdata, go, psel, pnum, phalf} = '0;
      srst = 1'b1;
      err_total = 0;
      tests_run = 0;
      repeat (12) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      chk("shown", 32'hF, {28'h0, shown});
      for (int i = 0; i < 9; i++) begin
         if (rows[i].w) wr(rows[i].a, rows[i].d);
         rc("row", rows[i].a, rows[i].e);
      end
      wr(8'h04, 32'h5);
      wr(8'h08, 32'h2);
      wr(8'h00, 32'h45);
      pulses(2'd1, 8'd2, 8'd4);
      rc("other pin", 8'h10, 32'h0);
      chk("start flags", 32'h3, f0());
      pulses(2'd0, 8'd3, 8'd4);
      chk("above lower", 32'h0, f0());
      pulses(2'd0, 8'd2, 8'd4);
      rc("up count", 8'h10, 32'h5);
      chk("upper flag", 32'h4, f0());
      wr(8'h00, 32'h41);
      pulses(2'd0, 8'd4, 8'd4);
      rc("down count", 8'h10, 32'h1);
      chk("lower flag", 32'h2, f0());
      wr(8'h00, 32'h44);
      pulses(2'd0, 8'd2, 8'd4);
      rc("disabled", 8'h10, 32'h1);
      wr(8'h0C, 32'hFFFFFFF9);
      wr(8'h00, 32'h4D);
      chk("preset flags", 32'h2, f0());
      rc("preset", 8'h10, 32'hFFFFFFF9);
      pulses(2'd0, 8'd1, 8'd40);
      rc("slow pulse", 8'h10, 32'hFFFFFFFA);
      wr(8'h00, 32'h47);
      pulses(2'd0, 8'd1, 8'd4);
      rc("clear", 8'h10, 32'h0);
      chk("zero flags", 32'h3, f0());
      for (int i = 0; i < 2; i++) begin
         wr(8'h0C, i ? CNT_MIN : CNT_MAX);
         wr(8'h00, i ? 32'h41 : 32'h45);
         wr(8'h00, i ? 32'h49 : 32'h4D);
         chk("range clear", 32'h0, {31'h0, range[0]});
         pulses(2'd0, 8'd1, 8'd4);
         rc("held", 8'h10, i ? CNT_MIN : CNT_MAX);
         chk("range set", 32'h1, {31'h0, range[0]});
      end
      wr(8'h20, 32'h55);
      pulses(2'd1, 8'd3, 8'd4);
      wr(8'h40, 32'h55);
      chk("owner", 32'h5, {28'h0, active});
      pulses(2'd1, 8'd2, 8'd4);
      rc("loser", 8'h30, 32'h3);
      rc("winner", 8'h50, 32'h2);
      wr(8'h80, 32'h0);
      wr(8'h20, 32'h57);
      rc("stop clear", 8'h30, 32'h3);
      wr(8'h20, 32'h55);
      wr(8'h80, 32'h1);
      rc("resume", 8'h30, 32'h3);
      rc("fresh", 8'h10, 32'h0);
      @(posedge mclk);
      srst <= 1'b1;
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      wr(8'h80, 32'h1);
      rc("supply loss", 8'h30, 32'h3);
      wr(8'h00, 32'h0);
      chk("hidden", 32'hE, {28'h0, shown});
      end_of_test();
   end
endmodule  // fast_counter_block_tb
